// ---- logic/flat_panel_grey_and_fit_mapper.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defines.svh"
module flat_panel_grey_and_fit_mapper
   import fpm_pkg::*;
#(
   parameter int LUT_DEPTH = 256
)
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Attribute palette write port
   input  wire logic        attrPalWr,
   input  wire logic [3:0]  attrPalIdx,
   input  wire logic [7:0]  attrPalData,
   // Colour DAC mirror write port
   input  wire logic        dacWr,
   input  wire logic [7:0]  dacIdx,
   input  wire logic [5:0]  dacRed,
   input  wire logic [5:0]  dacGreen,
   input  wire logic [5:0]  dacBlue,
   // Display state
   input  wire logic        lcdActive,
   input  wire logic        textMode,
   input  wire logic [9:0]  srcLines,
   input  wire logic [9:0]  panelLines,
   // Pixel stream in
   input  wire logic        frameStart,
   input  wire logic        lineStart,
   input  wire logic        pixValid,
   input  wire logic [3:0]  pixAttr,
   input  wire logic        pixIsFg,
   input  wire logic [3:0]  cellFg,
   input  wire logic [3:0]  cellBg,
   // Panel stream out
   output grey_t            greyOut,
   output logic             greyValid,
   // Fit controls
   output logic             forceEightDot,
   output logic             lineReplicate,
   output logic      [9:0]  vertStart
);

   // Register file.
   reg8_t lcdControlOne_reg;
   reg8_t userOptionsLow_reg;
   reg8_t userOptionsHigh_reg;
   reg8_t secondOptionsLow_reg;
   reg8_t secondOptionsHigh_reg;
   reg8_t lcdControlTwo_reg;
   reg8_t horizontalOffset_reg;
   reg8_t verticalOffset_reg;
   reg8_t panelControlOne_reg;
   reg8_t panelControlTwo_reg;

   logic [7:0]  wordIdx;
   logic        addrHit;
   logic        busWrite;
   reg8_t       readValue;

   // Attribute palette and pixel path.
   logic [7:0]  attrPalette_reg [16];
   logic [7:0]  dacIndex;
   grey_t       contrastGrey;
   grey_t       lookupGrey;
   grey_src_e   srcSel;
   logic        contrastOn;
   logic        bypassOn;

   // Horizontal fit.
   hcomp_e      hMode_reg;
   logic [9:0]  colStart_reg;
   logic [9:0]  xCount_reg;
   logic [3:0]  phase_reg;
   logic [9:0]  winStart;
   logic [10:0] winEnd;
   logic        keepPix;
   logic        holdPix;
   logic        mergePix;

   // Pipeline stage one.
   logic        s1Valid_reg;
   logic        s1Keep_reg;
   logic        s1Hold_reg;
   logic        s1Merge_reg;
   grey_src_e   s1Src_reg;
   grey_t       s1Contrast_reg;
   grey_t       s1Direct_reg;
   grey_t       s1Grey;
   grey_t       heldGrey_reg;

   // Vertical fit.
   logic [9:0]  rowOffset;
   logic [9:0]  spareLines;
   logic [9:0]  vertStart_next;

   // ---------------- APB slave ----------------

   always_comb begin
      wordIdx = paddr[9:2];
      addrHit = 1'b0;
      if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
         if (wordIdx == `IDX_LCD_CONTROL_ONE) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_USER_OPTIONS_LOW) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_USER_OPTIONS_HIGH) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_SECOND_OPTIONS_LOW) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_SECOND_OPTIONS_HIGH) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_LCD_CONTROL_TWO) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_HORIZONTAL_OFFSET) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_VERTICAL_OFFSET) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_PANEL_CONTROL_ONE) begin
            addrHit = 1'b1;
         end else if (wordIdx == `IDX_PANEL_CONTROL_TWO) begin
            addrHit = 1'b1;
         end
      end
   end

   always_comb begin
      readValue = 8'h00;
      if (wordIdx == `IDX_LCD_CONTROL_ONE) begin
         readValue = lcdControlOne_reg;
      end else if (wordIdx == `IDX_USER_OPTIONS_LOW) begin
         readValue = userOptionsLow_reg;
      end else if (wordIdx == `IDX_USER_OPTIONS_HIGH) begin
         readValue = userOptionsHigh_reg;
      end else if (wordIdx == `IDX_SECOND_OPTIONS_LOW) begin
         readValue = secondOptionsLow_reg;
      end else if (wordIdx == `IDX_SECOND_OPTIONS_HIGH) begin
         readValue = secondOptionsHigh_reg;
      end else if (wordIdx == `IDX_LCD_CONTROL_TWO) begin
         readValue = lcdControlTwo_reg;
      end else if (wordIdx == `IDX_HORIZONTAL_OFFSET) begin
         readValue = horizontalOffset_reg;
      end else if (wordIdx == `IDX_VERTICAL_OFFSET) begin
         readValue = verticalOffset_reg;
      end else if (wordIdx == `IDX_PANEL_CONTROL_ONE) begin
         readValue = panelControlOne_reg;
      end else if (wordIdx == `IDX_PANEL_CONTROL_TWO) begin
         readValue = panelControlTwo_reg;
      end
   end

   // The answer is prepared in the setup cycle, so every access has no wait state.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= !addrHit;
         prdata  <= (pwrite || !addrHit) ? 32'h0000_0000 : {24'h00_0000, readValue};
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   assign busWrite = psel && penable && pready && pwrite && addrHit;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         lcdControlOne_reg     <= `RESET_REG8;
         userOptionsLow_reg    <= `RESET_REG8;
         userOptionsHigh_reg   <= `RESET_REG8;
         secondOptionsLow_reg  <= `RESET_REG8;
         secondOptionsHigh_reg <= `RESET_REG8;
         lcdControlTwo_reg     <= `RESET_REG8;
         horizontalOffset_reg  <= `RESET_REG8;
         verticalOffset_reg    <= `RESET_REG8;
         panelControlOne_reg   <= `RESET_REG8;
         panelControlTwo_reg   <= `RESET_REG8;
      end else if (busWrite) begin
         if (wordIdx == `IDX_LCD_CONTROL_ONE) begin
            lcdControlOne_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_USER_OPTIONS_LOW) begin
            userOptionsLow_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_USER_OPTIONS_HIGH) begin
            userOptionsHigh_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_SECOND_OPTIONS_LOW) begin
            secondOptionsLow_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_SECOND_OPTIONS_HIGH) begin
            secondOptionsHigh_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_LCD_CONTROL_TWO) begin
            lcdControlTwo_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_HORIZONTAL_OFFSET) begin
            horizontalOffset_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_VERTICAL_OFFSET) begin
            verticalOffset_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_PANEL_CONTROL_ONE) begin
            panelControlOne_reg <= pwdata[7:0];
         end else if (wordIdx == `IDX_PANEL_CONTROL_TWO) begin
            panelControlTwo_reg <= pwdata[7:0];
         end
      end
   end

   // ---------------- Attribute palette ----------------

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         for (int i = 0; i < 16; i++) begin
            attrPalette_reg[i] <= `RESET_REG8;
         end
      end else if (attrPalWr && !panelControlTwo_reg[`BIT_PALETTE_LOCK]) begin
         attrPalette_reg[attrPalIdx] <= attrPalData;
      end
   end

   // ---------------- Grey source selection ----------------

   assign dacIndex = attrPalette_reg[pixAttr];

   max_contrast u_contrast (
      .cellFg  (cellFg),
      .cellBg  (cellBg),
      .pixIsFg (pixIsFg),
      .grey    (contrastGrey)
   );

   grey_lut #(
      .DEPTH (LUT_DEPTH)
   ) u_lut (
      .clk_sys (clk_sys),
      .wrEn    (dacWr),
      .wrIdx   (dacIdx),
      .red     (dacRed),
      .green   (dacGreen),
      .blue    (dacBlue),
      .rdIdx   (dacIndex),
      .rdGrey  (lookupGrey)
   );

   // Settings are read live, so a register write steers the very next pixel.
   always_comb begin
      contrastOn = panelControlTwo_reg[`BIT_MAX_CONTRAST] && textMode;
      bypassOn   = panelControlTwo_reg[`BIT_LOOKUP_BYPASS] || !lcdActive;
      if (contrastOn) begin
         srcSel = SRC_CONTRAST;
      end else if (bypassOn) begin
         srcSel = SRC_DIRECT;
      end else begin
         srcSel = SRC_LOOKUP;
      end
   end

   // ---------------- Horizontal fit ----------------

   // Mode and offset are taken at line start so a line is never split.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         hMode_reg    <= HC_LEFT;
         colStart_reg <= 10'h000;
      end else if (lineStart) begin
         hMode_reg    <= hcomp_e'(panelControlTwo_reg[`FIELD_HCOMP_HI:`FIELD_HCOMP_LO]);
         colStart_reg <= {1'b0, panelControlOne_reg[`BIT_COL_OFFSET_MSB],
                          horizontalOffset_reg};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         xCount_reg <= 10'h000;
         phase_reg  <= 4'h0;
      end else if (lineStart) begin
         xCount_reg <= 10'h000;
         phase_reg  <= 4'h0;
      end else if (pixValid) begin
         xCount_reg <= xCount_reg + 10'h001;
         phase_reg  <= (phase_reg == `NINTH_PHASE) ? 4'h0 : phase_reg + 4'h1;
      end
   end

   always_comb begin
      winStart = colStart_reg;
      if (hMode_reg == HC_RIGHT) begin
         winStart = colStart_reg + `RIGHT_START_DOT;
      end
      // One extra bit keeps the window end from wrapping for large column offsets.
      winEnd   = {1'b0, winStart} + {1'b0, `PANEL_WIDTH};
      keepPix  = 1'b1;
      holdPix  = 1'b0;
      mergePix = 1'b0;
      case (hMode_reg)
         HC_LEFT, HC_RIGHT: begin
            keepPix = (xCount_reg >= winStart) && (xCount_reg < winEnd);
         end
         HC_SKIP9: begin
            keepPix = (phase_reg != `NINTH_PHASE);
         end
         HC_OR89: begin
            holdPix  = (phase_reg == `EIGHTH_PHASE);
            keepPix  = !holdPix;
            mergePix = (phase_reg == `NINTH_PHASE);
         end
         default: begin
            keepPix = 1'b1;
         end
      endcase
   end

   // ---------------- Pixel pipeline ----------------

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s1Valid_reg    <= 1'b0;
         s1Keep_reg     <= 1'b0;
         s1Hold_reg     <= 1'b0;
         s1Merge_reg    <= 1'b0;
         s1Src_reg      <= SRC_LOOKUP;
         s1Contrast_reg <= 4'h0;
         s1Direct_reg   <= 4'h0;
      end else begin
         s1Valid_reg    <= pixValid && !lineStart;
         s1Keep_reg     <= keepPix;
         s1Hold_reg     <= holdPix;
         s1Merge_reg    <= mergePix;
         s1Src_reg      <= srcSel;
         s1Contrast_reg <= contrastGrey;
         s1Direct_reg   <= dacIndex[3:0];
      end
   end

   always_comb begin
      case (s1Src_reg)
         SRC_CONTRAST: s1Grey = s1Contrast_reg;
         SRC_DIRECT:   s1Grey = s1Direct_reg;
         default:      s1Grey = lookupGrey;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         heldGrey_reg <= 4'h0;
      end else if (s1Valid_reg && s1Hold_reg) begin
         heldGrey_reg <= s1Grey;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         greyOut   <= 4'h0;
         greyValid <= 1'b0;
      end else begin
         greyValid <= s1Valid_reg && s1Keep_reg;
         if (s1Valid_reg && s1Keep_reg) begin
            greyOut <= s1Merge_reg ? (s1Grey | heldGrey_reg) : s1Grey;
         end
      end
   end

   // ---------------- Vertical fit ----------------

   always_comb begin
      rowOffset  = {1'b0, panelControlOne_reg[`BIT_ROW_OFFSET_MSB], verticalOffset_reg};
      spareLines = panelLines - srcLines;
      vertStart_next = 10'h000;
      if (srcLines < panelLines && !lcdControlTwo_reg[`BIT_SCAN_REPLICATE]) begin
         if (panelControlOne_reg[`BIT_AUTO_CENTER]) begin
            vertStart_next = {1'b0, spareLines[9:1]};
         end else begin
            vertStart_next = rowOffset;
         end
      end
   end

   // Frame-level controls change only at frame start to avoid tearing.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         vertStart     <= 10'h000;
         lineReplicate <= 1'b0;
         forceEightDot <= 1'b0;
      end else if (frameStart) begin
         vertStart     <= vertStart_next;
         lineReplicate <= lcdControlTwo_reg[`BIT_SCAN_REPLICATE];
         forceEightDot <= lcdControlOne_reg[`BIT_FORCE_EIGHT_DOT];
      end
   end

endmodule : flat_panel_grey_and_fit_mapper
`default_nettype wire

// ---- logic/fpm_defines.svh ----
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

`define IDX_LCD_CONTROL_ONE        8'h8A
`define IDX_USER_OPTIONS_LOW       8'hB0
`define IDX_USER_OPTIONS_HIGH      8'hB1
`define IDX_SECOND_OPTIONS_LOW     8'hB2
`define IDX_SECOND_OPTIONS_HIGH    8'hB3
`define IDX_LCD_CONTROL_TWO        8'hC2
`define IDX_HORIZONTAL_OFFSET      8'hD0
`define IDX_VERTICAL_OFFSET        8'hD2
`define IDX_PANEL_CONTROL_ONE      8'hD4
`define IDX_PANEL_CONTROL_TWO      8'hD5

`define BIT_FORCE_EIGHT_DOT        6
`define BIT_SCAN_REPLICATE         1
`define BIT_ROW_OFFSET_MSB         6
`define BIT_COL_OFFSET_MSB         4
`define BIT_AUTO_CENTER            3
`define BIT_LOOKUP_BYPASS          7
`define BIT_MAX_CONTRAST           5
`define BIT_PALETTE_LOCK           2
`define FIELD_HCOMP_HI             1
`define FIELD_HCOMP_LO             0

`define RESET_REG8                 8'h00
`define PANEL_WIDTH                10'h280
`define RIGHT_START_DOT            10'h050
`define NINTH_PHASE                4'h8
`define EIGHTH_PHASE               4'h7
`define GREY_WHITE                 4'hF
`define GREY_BLACK                 4'h0

`endif

// ---- logic/fpm_pkg.sv ----
package fpm_pkg;

   typedef enum logic [1:0] {
      HC_LEFT  = 2'h0,
      HC_RIGHT = 2'h1,
      HC_SKIP9 = 2'h2,
      HC_OR89  = 2'h3
   } hcomp_e;

   typedef enum logic [2:0] {
      SRC_CONTRAST = 3'h1,
      SRC_DIRECT   = 3'h2,
      SRC_LOOKUP   = 3'h4
   } grey_src_e;

   typedef logic [3:0] grey_t;
   typedef logic [7:0] reg8_t;

endpackage : fpm_pkg

// ---- logic/grey_lut.sv ----
`timescale 1ns/1ps
`default_nettype none
module grey_lut
   import fpm_pkg::*;
#(
   parameter int DEPTH = 256
)
(
   // Clock
   input  wire logic       clk_sys,
   // Colour DAC mirror write
   input  wire logic       wrEn,
   input  wire logic [7:0] wrIdx,
   input  wire logic [5:0] red,
   input  wire logic [5:0] green,
   input  wire logic [5:0] blue,
   // Lookup
   input  wire logic [7:0] rdIdx,
   output grey_t           rdGrey
);

   grey_t      table_reg [DEPTH];
   logic [9:0] colourSum;
   logic [9:0] scaledSum;

   // Weighting the sum by 5/4 lets full white reach a near-top shade.
   always_comb begin
      colourSum = {4'h0, red} + {4'h0, green} + {4'h0, blue};
      scaledSum = colourSum + {2'h0, colourSum[9:2]};
   end

   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         table_reg[wrIdx] <= scaledSum[7:4];
      end
   end

   always_ff @(posedge clk_sys) begin
      rdGrey <= table_reg[rdIdx];
   end

endmodule : grey_lut
`default_nettype wire

// ---- logic/max_contrast.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defines.svh"
module max_contrast
   import fpm_pkg::*;
(
   // Cell attributes
   input  wire logic [3:0] cellFg,
   input  wire logic [3:0] cellBg,
   input  wire logic       pixIsFg,
   // Result
   output grey_t           grey
);

   always_comb begin
      if (cellFg == cellBg) begin
         grey = cellFg;
      end else if (cellFg > cellBg) begin
         grey = pixIsFg ? `GREY_WHITE : `GREY_BLACK;
      end else begin
         grey = pixIsFg ? `GREY_BLACK : `GREY_WHITE;
      end
   end

endmodule : max_contrast
`default_nettype wire

// ---- test/flat_panel_grey_and_fit_mapper_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defines.svh"
module flat_panel_grey_and_fit_mapper_test
   import fpm_pkg::*;
;
   logic        clk_sys, reset_n, psel, penable, pwrite, attrPalWr, dacWr, lcdActive;
   logic        textMode, frameStart, lineStart, pixValid, pixIsFg, pready, pslverr;
   logic        greyValid, forceEightDot, lineReplicate, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [3:0]  attrPalIdx, pixAttr, cellFg, cellBg;
   logic [7:0]  attrPalData, dacIdx, pc1, pc2, hoff, c1, c2, voff;
   logic [5:0]  dacRed, dacGreen, dacBlue;
   logic [9:0]  srcLines, panelLines, vertStart;
   logic [14:0] stim [720];
   logic [7:0]  pal [16];
   grey_t       lut [256];
   grey_t       greyOut;
   grey_t       expQ [$];
   int          failures, checkCount, cycles;
   logic [7:0]  cfgTab [5] = '{8'h00, 8'h80, 8'h84, 8'hA4, 8'h20};
   logic [7:0]  idxTab [10] = '{`IDX_LCD_CONTROL_ONE, `IDX_USER_OPTIONS_LOW,
      `IDX_USER_OPTIONS_HIGH, `IDX_SECOND_OPTIONS_LOW, `IDX_SECOND_OPTIONS_HIGH,
      `IDX_LCD_CONTROL_TWO, `IDX_HORIZONTAL_OFFSET, `IDX_VERTICAL_OFFSET,
      `IDX_PANEL_CONTROL_ONE, `IDX_PANEL_CONTROL_TWO};

   flat_panel_grey_and_fit_mapper DUT (
      .clk_sys, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .attrPalWr, .attrPalIdx, .attrPalData, .dacWr, .dacIdx, .dacRed, .dacGreen,
      .dacBlue, .lcdActive, .textMode, .srcLines, .panelLines, .frameStart, .lineStart,
      .pixValid, .pixAttr, .pixIsFg, .cellFg, .cellBg, .greyOut, .greyValid, .forceEightDot,
      .lineReplicate, .vertStart
   );
   panel_sink sink (.clk_sys, .lineStart, .greyOut, .greyValid);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         test_done();
      end
   end

   task automatic test_done();
      if (failures == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic chkVal(string name, logic [31:0] exp, logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s exp %h got %h", name, exp, got);
      end
   endtask : chkVal

   task automatic chkGrey(int idx, grey_t exp, grey_t got);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] grey %0d exp %h got %h", idx, exp, got);
      end
   endtask : chkGrey

   function automatic logic [11:0] ba(logic [7:0] i);
      return {2'h0, i, 2'h0};
   endfunction : ba

   // One transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic palWr(logic [3:0] i, logic [7:0] d);
      @(posedge clk_sys);
      attrPalWr   <= 1'b1;
      attrPalIdx  <= i;
      attrPalData <= d;
      if (!pc2[2])
         pal[i] = d;
      @(posedge clk_sys);
      attrPalWr   <= 1'b0;
   endtask : palWr

   function automatic grey_t greyOfDac(logic [17:0] c);
      logic [7:0] s;
      s = c[17:12] + c[11:6] + c[5:0];
      s = s + (s >> 2);
      return s[7:4];
   endfunction : greyOfDac

   // Stimulus word: lcd, text, foreground pixel, cell fg, cell bg, attribute.
   function automatic grey_t shadeOf(logic [14:0] s);
      if (pc2[5] && s[13]) begin
         if (s[11:8] == s[7:4])
            return s[11:8];
         return ((s[11:8] > s[7:4]) == s[12]) ? 4'hF : 4'h0;
      end
      if (pc2[7] || !s[14])
         return pal[s[3:0]][3:0];
      return lut[pal[s[3:0]]];
   endfunction : shadeOf

   function automatic void mkExp(int n);
      int st;
      expQ = {};
      st = {pc1[4], hoff} + (pc2[0] ? 80 : 0);
      for (int x = 0; x < n; x++) begin
         case (pc2[1:0])
            2'h0, 2'h1: if (x >= st && x < st + 640) expQ.push_back(shadeOf(stim[x]));
            2'h2: if (x % 9 != 8) expQ.push_back(shadeOf(stim[x]));
            default: if (x % 9 == 8) expQ.push_back(shadeOf(stim[x]) | shadeOf(stim[x - 1]));
                     else if (x % 9 != 7) expQ.push_back(shadeOf(stim[x]));
         endcase
      end
   endfunction : mkExp

   // The pixel offered with the line marker must be discarded.
   task automatic runLine(int n);
      @(posedge clk_sys);
      lineStart <= 1'b1;
      pixValid  <= 1'b1;
      for (int x = 0; x < n; x++) begin
         @(posedge clk_sys);
         lineStart <= 1'b0;
         {lcdActive, textMode, pixIsFg, cellFg, cellBg, pixAttr} <= stim[x];
      end
      @(posedge clk_sys);
      pixValid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chkVal("kept", 32'(expQ.size()), 32'(sink.kept));
      foreach (expQ[i]) chkGrey(i, expQ[i], sink.shade[i]);
   endtask : runLine

   initial begin
      {psel, penable, pwrite, attrPalWr, dacWr, lcdActive, textMode, frameStart, lineStart,
       pixValid, pixIsFg, paddr, pwdata, attrPalIdx, pixAttr, cellFg, cellBg, attrPalData,
       dacIdx, dacRed, dacGreen, dacBlue, srcLines, panelLines, reset_n} = '0;
      {failures, checkCount, cycles, pc1, pc2, hoff} = '0;
      foreach (pal[i]) pal[i] = 8'h00;
      void'($urandom(32'h7154B030));
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      foreach (idxTab[i]) begin
         apb(1'b0, ba(idxTab[i]), 32'h0);
         chkVal("reset value", 32'h0, rd);
         v = $urandom;
         apb(1'b1, ba(idxTab[i]), v);
         apb(1'b0, ba(idxTab[i]), 32'h0);
         chkVal("readback", {24'h0, v[7:0]}, rd);
      end
      apb(1'b0, 12'h004, 32'h0);
      chkVal("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, ba(`IDX_LCD_CONTROL_ONE), 32'h3C);
      apb(1'b1, 12'h229, 32'hFF);
      chkVal("misaligned", 32'h1, {31'h0, err});
      apb(1'b0, ba(`IDX_LCD_CONTROL_ONE), 32'h0);
      chkVal("kept value", 32'h3C, rd);
      apb(1'b1, ba(`IDX_PANEL_CONTROL_ONE), 32'h0);
      apb(1'b1, ba(`IDX_HORIZONTAL_OFFSET), 32'h0);
      for (int i = 0; i < 256; i++) begin
         @(posedge clk_sys);
         v = $urandom;
         dacWr  <= 1'b1;
         dacIdx <= i[7:0];
         {dacRed, dacGreen, dacBlue} <= v[17:0];
         lut[i] = greyOfDac(v[17:0]);
      end
      @(posedge clk_sys);
      dacWr <= 1'b0;
      foreach (cfgTab[k]) begin
         pc2 = cfgTab[k];
         apb(1'b1, ba(`IDX_PANEL_CONTROL_TWO), {24'h0, pc2});
         repeat (4) palWr(4'($urandom), 8'($urandom));
         for (int x = 0; x < 48; x++) begin
            stim[x] = 15'($urandom) | 15'h2000;
            if (x % 5 == 0)
               stim[x][11:8] = stim[x][7:4];
         end
         mkExp(48);
         runLine(48);
      end
      for (int m = 0; m < 6; m++) begin
         pc2 = 8'h80 | 8'(m % 4);
         pc1 = (m == 1) ? 8'h00 : 8'($urandom) & 8'h10;
         hoff = (m == 1) ? 8'h00 : 8'($urandom);
         apb(1'b1, ba(`IDX_PANEL_CONTROL_TWO), {24'h0, pc2});
         apb(1'b1, ba(`IDX_PANEL_CONTROL_ONE), {24'h0, pc1});
         apb(1'b1, ba(`IDX_HORIZONTAL_OFFSET), {24'h0, hoff});
         foreach (stim[x]) stim[x] = 15'($urandom) & 15'h5FFF;
         mkExp(720);
         runLine(720);
      end
      for (int t = 0; t < 10; t++) begin
         {c1, c2, pc1, voff} = $urandom;
         apb(1'b1, ba(`IDX_LCD_CONTROL_ONE), {24'h0, c1});
         apb(1'b1, ba(`IDX_LCD_CONTROL_TWO), {24'h0, c2});
         apb(1'b1, ba(`IDX_PANEL_CONTROL_ONE), {24'h0, pc1});
         apb(1'b1, ba(`IDX_VERTICAL_OFFSET), {24'h0, voff});
         srcLines   <= 10'(300 + $urandom % 300);
         panelLines <= 10'(400 + $urandom % 200);
         @(posedge clk_sys);
         frameStart <= 1'b1;
         @(posedge clk_sys);
         frameStart <= 1'b0;
         @(posedge clk_sys);
         if (srcLines >= panelLines || c2[1])
            v = 32'h0;
         else if (pc1[3])
            v = 32'((panelLines - srcLines) >> 1);
         else
            v = {23'h0, pc1[6], voff};
         chkVal("vertStart", v, {22'h0, vertStart});
         chkVal("replicate", {31'h0, c2[1]}, {31'h0, lineReplicate});
         chkVal("eight dot", {31'h0, c1[6]}, {31'h0, forceEightDot});
      end
      test_done();
   end
endmodule : flat_panel_grey_and_fit_mapper_test
`default_nettype wire

// ---- test/fpm_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpm_asserts
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Register bus
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // Pixel stream and fit controls
   input  wire logic        frameStart,
   input  wire logic        lineStart,
   input  wire logic        pixValid,
   input  wire logic        greyValid,
   input  wire logic [9:0]  srcLines,
   input  wire logic [9:0]  panelLines,
   input  wire logic        forceEightDot,
   input  wire logic        lineReplicate,
   input  wire logic [9:0]  vertStart
);
   logic [10:0] keptCount;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Counts kept pixels of a line once the previous line's pixels have drained.
   always_ff @(posedge clk_sys) begin
      if (!reset_n || $past(lineStart, 2))
         keptCount <= 11'h000;
      else if (greyValid)
         keptCount <= keptCount + 11'h001;
   end

   AST_PREADY_NEXT: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("pready is not one cycle after setup");
   AST_MISALIGNED_ERR: assert property (
      psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
      else $error("misaligned access not refused");
   AST_GREY_CAUSE: assert property (
      greyValid |-> $past(pixValid && !lineStart, 2))
      else $error("grey output without a kept pixel two cycles before");
   AST_LINE_LIMIT: assert property (
      keptCount <= 11'h280)
      else $error("more than 640 pixels kept on one line");
   AST_FIT_AT_FRAME: assert property (
      !$past(frameStart) |-> $stable(vertStart) && $stable(lineReplicate) && $stable(forceEightDot))
      else $error("fit outputs changed away from a frame start");
   AST_REPL_TOP: assert property (
      $past(frameStart) && lineReplicate |-> vertStart == 10'h000)
      else $error("replicated image not placed at the top");
   AST_SHORT_ONLY: assert property (
      frameStart && srcLines >= panelLines |=> vertStart == 10'h000)
      else $error("tall mode was offset vertically");
   AST_ROW_NINE_BITS: assert property (
      vertStart[9] == 1'b0)
      else $error("vertical start exceeds nine bits");
endmodule : fpm_asserts

bind flat_panel_grey_and_fit_mapper fpm_asserts u_asserts (
   .clk_sys, .reset_n, .paddr, .psel, .penable, .pready, .pslverr, .frameStart, .lineStart,
   .pixValid, .greyValid, .srcLines, .panelLines, .forceEightDot, .lineReplicate, .vertStart
);
`default_nettype wire

// ---- test/panel_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module panel_sink
   import fpm_pkg::*;
(
   // Clock and line marker
   input  wire logic  clk_sys,
   input  wire logic  lineStart,
   // Grey stream from the mapper
   input  wire grey_t greyOut,
   input  wire logic  greyValid
);
   grey_t      shade [1024];
   int         kept = 0;
   logic [1:0] mark = 2'h0;

   // The panel restarts its column two cycles after a line marker, when stale pixels are out.
   always @(posedge clk_sys) begin
      mark <= {mark[0], lineStart};
      if (mark[1])
         kept <= 0;
      else if (greyValid) begin
         shade[kept] <= greyOut;
         kept        <= kept + 1;
      end
   end
endmodule : panel_sink
`default_nettype wire
